/* File: testbench/tb_uft_top.sv */
// Self-checking bench for the frame formatter and transmit path
`timescale 1ns/10ps
module tb_uft_top;
  import uft_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        on = 1'b1;
  logic        cwr = 1'b0;
  uft_ctrl_t   ctl = '0;
  logic        bwr = 1'b0;
  logic [15:0] div = 16'h000A;
  logic [2:0]  frac = 3'h3;
  logic        srd = 1'b0;
  logic        dwr = 1'b0;
  logic [7:0]  din = 8'h00;
  logic [3:0]  nb = 4'hB;
  uft_ctrl_t   ctl_o;
  uft_stat_t   st;
  logic        tx, tx_oe, rx_sel;
  logic [11:0] frame;
  int          nfr;
  int          fail_count = 0;
  int          n_tests = 0;
  always #5 clk = ~clk;
  uft_top i_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .PORT_ON_I(on),
    .CTRL_WR_I(cwr), .CTRL_I(ctl), .BAUD_WR_I(bwr), .BAUD_DIV_I(div),
    .FRACTION_ADJUST_I(frac), .STATUS_RD_I(srd), .DATA_WR_I(dwr),
    .DATA_I(din), .CTRL_O(ctl_o), .STATUS_O(st), .TX_O(tx),
    .TX_OE_O(tx_oe), .RX_SEL_O(rx_sel));
  uft_rx_model i_peer (.clk_i(clk), .line_i(tx), .div_i(div),
    .frac_i(frac), .nbits_i(nb), .frame_o(frame), .nfr_o(nfr));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic uft_ctrl_t mk(logic te, logic wl, logic pe,
                                   logic [1:0] pt, logic n9, logic ad);
    uft_ctrl_t c;
    c = '0;
    c.transmit_enable = te;
    c.receive_enable = te;
    c.word_length_select = wl;
    c.parity_enable = pe;
    c.parity_type_field = uft_par_t'(pt);
    c.rx_stop_count_select = n9;
    c.ninth_transmit_bit = n9;
    c.addr_detect_enable = ad;
    return c;
  endfunction
  // Expected line bits, start first; unused top bit of 8-bit frame reads 1
  function automatic logic [11:0] efr(uft_ctrl_t c, logic [7:0] d);
    logic [8:0] f;
    logic       p;
    f = {c.word_length_select ? c.ninth_transmit_bit : 1'b1, d};
    p = c.word_length_select ? ^d : ^d[6:0];
    case (c.parity_type_field)
      UFT_PAR_ODD:   p = ~p;
      UFT_PAR_MARK:  p = 1'b1;
      UFT_PAR_SPACE: p = 1'b0;
      default:       p = p;
    endcase
    if (c.parity_enable && !c.addr_detect_enable) begin
      if (c.word_length_select) f[8] = p;
      else f[7] = p;
    end
    return {2'b11, f, 1'b0};
  endfunction
  function automatic int flen(input logic [3:0] n);
    logic [3:0] a;
    int         l;
    a = 4'h0;
    l = 0;
    for (int i = 0; i < n; i++) begin
      a = a + frac;
      l += div + a[3];
      a[3] = 1'b0;
    end
    return l;
  endfunction
  task automatic setc(input uft_ctrl_t c);
    @(posedge clk);
    ctl <= c;
    cwr <= 1'b1;
    nb <= c.word_length_select ? 4'hC : 4'hB;
    @(posedge clk);
    cwr <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] b, input logic arm);
    if (arm) begin
      @(posedge clk);
      srd <= 1'b1;
    end
    @(posedge clk);
    srd <= 1'b0;
    dwr <= 1'b1;
    din <= b;
    @(posedge clk);
    dwr <= 1'b0;
  endtask
  task automatic wait_n(input int n);
    int k;
    k = 0;
    while (nfr < n && k < 3000) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic send(input uft_ctrl_t c, input logic [7:0] d);
    int n0, k;
    n0 = nfr;
    setc(c);
    wr(d, 1'b1);
    k = 0;
    #1;
    while (tx !== 1'b0 && k < 3) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({st.transmit_room_flag, st.transmit_idle_flag}, 2'b10);
    chk({tx_oe, rx_sel}, 2'b11);
    k = 0;
    while (st.transmit_idle_flag !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(16'(k), 16'(flen(nb)));
    chk(16'(nfr), 16'(n0 + 1));
    chk(frame, efr(c, d));
  endtask
  task automatic t_reset();
    #1;
    chk(ctl_o, '0);
    chk({st.transmit_room_flag, st.transmit_idle_flag}, 2'b11);
    chk({tx, tx_oe}, 2'b10);
    setc(mk(0, 0, 0, 2'h0, 0, 0));
    @(posedge clk);
    bwr <= 1'b1;
    @(posedge clk);
    bwr <= 1'b0;
  endtask
  task automatic t_formats();
    for (int p = 0; p < 4; p++)
      send(mk(1, 0, 1, p[1:0], 0, 0), 8'hA5 ^ p[7:0]);
    send(mk(1, 0, 0, 2'h0, 0, 0), 8'h6B);
    send(mk(1, 1, 0, 2'h0, 1, 0), 8'h3C);
    send(mk(1, 1, 1, 2'h1, 0, 0), 8'h81);
    send(mk(1, 0, 1, 2'h2, 0, 1), 8'h80);
  endtask
  task automatic t_b2b();
    int n0;
    n0 = nfr;
    setc(mk(1, 0, 0, 2'h0, 0, 0));
    wr(8'h12, 1'b1);
    wr(8'h34, 1'b1);
    #1;
    chk(st.transmit_room_flag, 1'b0);
    wr(8'h56, 1'b1);
    wait_n(n0 + 2);
    chk(frame, efr(ctl, 8'h34));
    wr(8'h78, 1'b0);
    repeat (300) @(posedge clk);
    chk(16'(nfr), 16'(n0 + 2));
  endtask
  task automatic t_order();
    int n0;
    n0 = nfr;
    setc(mk(0, 0, 0, 2'h0, 0, 0));
    wr(8'hC3, 1'b1);
    repeat (50) @(posedge clk);
    chk({tx, st.transmit_room_flag}, 2'b10);
    setc(mk(1, 0, 0, 2'h0, 0, 0));
    wait_n(n0 + 1);
    chk(frame, efr(ctl, 8'hC3));
  endtask
  task automatic t_abort();
    setc(mk(1, 0, 0, 2'h0, 0, 0));
    wr(8'h00, 1'b1);
    repeat (25) @(posedge clk);
    setc(mk(0, 0, 0, 2'h0, 0, 0));
    repeat (2) @(posedge clk);
    #1;
    chk({tx, tx_oe, st.transmit_idle_flag}, 3'b101);
    repeat (200) @(posedge clk);
  endtask
  task automatic t_off();
    uft_ctrl_t c;
    int        n0;
    c = mk(1, 1, 1, 2'h1, 1, 0);
    c.break_send = 1'b1;
    setc(c);
    wr(8'h55, 1'b1);
    wr(8'hAA, 1'b1);
    repeat (20) @(posedge clk);
    on <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    c.transmit_enable = 1'b0;
    c.receive_enable = 1'b0;
    c.break_send = 1'b0;
    chk(ctl_o, c);
    chk(st, 11'h700);
    chk({tx, tx_oe, rx_sel}, 3'b100);
    repeat (200) @(posedge clk);
    n0 = nfr;
    on <= 1'b1;
    setc(mk(1, 1, 1, 2'h1, 1, 0));
    repeat (300) @(posedge clk);
    chk(16'(nfr), 16'(n0));
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_formats();
    t_b2b();
    t_order();
    t_abort();
    t_off();
    summarize();
  end
  // About 2500 cycles of traffic expected; allow a wide margin
  initial begin
    #500000;
    fail_count++;
    summarize();
  end
endmodule

/* File: testbench/uft_rx_model.sv */
// Behavioural serial receiver that decodes frames on the transmit line
`timescale 1ns/10ps
module uft_rx_model (
  input  wire logic        clk_i,
  input  wire logic        line_i,
  input  wire logic [15:0] div_i,
  input  wire logic [2:0]  frac_i,
  input  wire logic [3:0]  nbits_i,
  output logic [11:0]      frame_o,
  output int               nfr_o
);
  int         len;
  logic [3:0] acc;
  initial begin
    frame_o = '1;
    nfr_o = 0;
  end
  // Rx_stop_count_select at mid second stop bit so a back-to-back start edge is not missed
  always begin
    @(negedge line_i);
    acc = 4'h0;
    frame_o = '1;
    for (int i = 0; i < nbits_i; i++) begin
      acc = acc + frac_i;
      len = div_i + acc[3];
      acc[3] = 1'b0;
      if (i > 0) begin
        repeat (len - len / 2) @(posedge clk_i);
      end
      repeat (len / 2) @(posedge clk_i);
      frame_o[i] = line_i;
    end
    nfr_o++;
  end
endmodule

/* File: verilog/uft_baud_gen.sv */
// Bit-time generator with fractional stretch accumulator
`timescale 1ns/10ps
`include "uft_cfg.svh"
module uft_baud_gen #(
  parameter int DIV_W = `UFT_DIV_W
) (
  input  wire logic             SYS_CLK_I,
  input  wire logic             SYS_RST_I,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic [2:0]       frac_i,
  output logic                  tick_o
);
  import uft_pkg::*;

  if (DIV_W != 16) begin : g_chk
    $error("uft_baud_gen serves only a 16-bit divider");
  end

  uft_baud_t q;
  uft_baud_t d;
  logic [3:0]  sum;
  logic [15:0] limit;

  // A zero divider would never tick, so it is treated as one cycle
  always_comb begin
    limit = (div_i == 16'h0000) ? 16'h0000 : div_i - 16'h0001;
    limit = limit + {15'h0000, q.ext};
    tick_o = run_i && (q.cnt == limit);
    sum = {1'b0, q.acc} + {1'b0, frac_i};
    d = q;
    if (!run_i) begin
      d.cnt = 16'h0000;
      d.acc = frac_i;
      d.ext = 1'b0;
    end else if (tick_o) begin
      d.cnt = 16'h0000;
      d.acc = sum[2:0];
      d.ext = sum[3];
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_stretch_carry: assert property (
    tick_o && sum[3] && div_i > 16'h0001 |=>
      q.ext && q.cnt == 16'h0000 && !tick_o)
    else $error("carry did not stretch next bit");
endmodule

/* File: verilog/uft_cfg.svh */
// Offsets-free constants: reset values, frame counts and field widths
`ifndef UFT_CFG_SVH
`define UFT_CFG_SVH

`define UFT_DIV_W        16
`define UFT_FRAC_W       3
`define UFT_CNT_W        3
`define UFT_DIV_RST      16'h0000
`define UFT_FRAC_RST     3'h0
`define UFT_BITS_SHORT   4'h8
`define UFT_BITS_LONG    4'h9
`define UFT_TX_RX_STOP_COUNT_SELECT     2'h2
`define UFT_MSB_SHORT    4'h7
`define UFT_MSB_LONG     4'h8
`define UFT_FILL_EMPTY   3'h0

`endif

/* File: verilog/uft_pkg.sv */
// Types shared by the serial port frame and transmitter logic
package uft_pkg;

  typedef enum logic [1:0] {
    UFT_PAR_EVEN  = 2'b00,
    UFT_PAR_ODD   = 2'b01,
    UFT_PAR_MARK  = 2'b10,
    UFT_PAR_SPACE = 2'b11
  } uft_par_t;

  typedef enum logic [1:0] {
    UFT_ST_IDLE  = 2'b00,
    UFT_ST_START = 2'b01,
    UFT_ST_DATA  = 2'b10,
    UFT_ST_STOP  = 2'b11
  } uft_st_t;

  typedef struct packed {
    logic     transmit_enable;
    logic     receive_enable;
    logic     break_send;
    logic     word_length_select;
    logic     parity_enable;
    uft_par_t parity_type_field;
    logic     rx_stop_count_select;
    logic     ninth_transmit_bit;
    logic     addr_detect_enable;
  } uft_ctrl_t;

  typedef struct packed {
    logic       transmit_room_flag;
    logic       transmit_idle_flag;
    logic       receive_idle_flag;
    logic       receive_available_flag;
    logic       overrun_flag;
    logic       framing_error_flag;
    logic       parity_error_flag;
    logic       noise_flag;
    logic [2:0] receive_fill_count;
  } uft_stat_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0]  acc;
    logic        ext;
  } uft_baud_t;

endpackage

/* File: verilog/uft_top.sv */
// Serial port frame formatter and transmit path with holding register
`timescale 1ns/10ps
`include "uft_cfg.svh"
module uft_top #(
  parameter int DIV_W = `UFT_DIV_W
) (
  input  wire logic               SYS_CLK_I,
  input  wire logic               SYS_RST_I,
  input  wire logic               PORT_ON_I,
  input  wire logic               CTRL_WR_I,
  input  wire uft_pkg::uft_ctrl_t CTRL_I,
  input  wire logic               BAUD_WR_I,
  input  wire logic [DIV_W-1:0]   BAUD_DIV_I,
  input  wire logic [2:0]         FRACTION_ADJUST_I,
  input  wire logic               STATUS_RD_I,
  input  wire logic               DATA_WR_I,
  input  wire logic [7:0]         DATA_I,
  output uft_pkg::uft_ctrl_t      CTRL_O,
  output uft_pkg::uft_stat_t      STATUS_O,
  output logic                    TX_O,
  output logic                    TX_OE_O,
  output logic                    RX_SEL_O
);
  import uft_pkg::*;

  if (DIV_W != 16) begin : g_chk
    $error("uft_top serves only a 16-bit divider");
  end

  typedef struct packed {
    uft_ctrl_t        ctrl;
    logic [DIV_W-1:0] div;
    logic [2:0]       frac;
    logic [7:0]       hold;
    logic             hold_valid;
    logic             armed;
    logic             tx_idle;
    uft_st_t          st;
    logic [8:0]       shift;
    logic [3:0]       bit_cnt;
    logic             tx;
  } uft_state_t;

  uft_state_t q;
  uft_state_t d;
  logic       tick;
  logic       tx_go;
  logic       write_ok;
  logic       load;
  logic [7:0] load_data;
  logic [3:0] nbits;

  // Build the data field; MSB position may carry parity or address
  function automatic logic [8:0] uft_frame(input logic [7:0] data,
                                           input uft_ctrl_t  c);
    logic [8:0] f;
    logic       p;
    f = {c.ninth_transmit_bit, data};
    p = c.word_length_select ? ^data : ^data[6:0];
    case (c.parity_type_field)
      UFT_PAR_EVEN:  p = p;
      UFT_PAR_ODD:   p = ~p;
      UFT_PAR_MARK:  p = 1'b1;
      UFT_PAR_SPACE: p = 1'b0;
      default:       p = 1'b0;
    endcase
    // Address mode leaves the MSB as software wrote it
    if (c.parity_enable && !c.addr_detect_enable) begin
      if (c.word_length_select) begin
        f[8] = p;
      end else begin
        f[7] = p;
      end
    end
    return f;
  endfunction

  uft_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .SYS_CLK_I (SYS_CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .run_i     (q.st != UFT_ST_IDLE),
    .div_i     (q.div),
    .frac_i    (q.frac),
    .tick_o    (tick)
  );

  always_comb begin
    d = q;
    load = 1'b0;
    load_data = q.hold;
    nbits = q.ctrl.word_length_select ? `UFT_BITS_LONG : `UFT_BITS_SHORT;
    tx_go = PORT_ON_I && q.ctrl.transmit_enable;
    // Blocked unless the port is on, room is there and status was read first
    write_ok = DATA_WR_I && PORT_ON_I && !q.hold_valid
               && q.armed;
    if (CTRL_WR_I) begin
      d.ctrl = CTRL_I;
    end
    if (BAUD_WR_I) begin
      d.div = BAUD_DIV_I;
      d.frac = FRACTION_ADJUST_I;
    end
    if (STATUS_RD_I) begin
      d.armed = 1'b1;
    end else if (DATA_WR_I) begin
      d.armed = 1'b0;
    end
    if (write_ok) begin
      d.hold = DATA_I;
      d.hold_valid = 1'b1;
      d.tx_idle = 1'b0;
    end
    case (q.st)
      UFT_ST_IDLE: begin
        if (tx_go && write_ok) begin
          load = 1'b1;
          load_data = DATA_I;
          d.hold_valid = 1'b0;
        end else if (tx_go && q.hold_valid) begin
          load = 1'b1;
        end
      end
      UFT_ST_START: begin
        if (tick) begin
          d.st = UFT_ST_DATA;
          d.bit_cnt = 4'h0;
        end
      end
      UFT_ST_DATA: begin
        if (tick) begin
          d.shift = {1'b1, q.shift[8:1]};
          if (q.bit_cnt == nbits - 4'h1) begin
            d.st = UFT_ST_STOP;
            d.bit_cnt = 4'h0;
          end else begin
            d.bit_cnt = q.bit_cnt + 4'h1;
          end
        end
      end
      UFT_ST_STOP: begin
        if (tick) begin
          if (q.bit_cnt == {2'h0, `UFT_TX_RX_STOP_COUNT_SELECT} - 4'h1) begin
            d.st = UFT_ST_IDLE;
            // Set wins over a clearing write in the same cycle
            d.tx_idle = 1'b1;
            if (tx_go && q.hold_valid) begin
              load = 1'b1;
            end
          end else begin
            d.bit_cnt = q.bit_cnt + 4'h1;
          end
        end
      end
      default: begin
        d.st = UFT_ST_IDLE;
      end
    endcase
    if (load) begin
      if (load_data == q.hold) begin
        d.hold_valid = write_ok && q.st != UFT_ST_IDLE;
      end
      if (q.st != UFT_ST_IDLE || !write_ok) begin
        d.hold_valid = write_ok;
      end
      d.st = UFT_ST_START;
      d.shift = uft_frame(load_data, q.ctrl);
      d.bit_cnt = 4'h0;
    end
    if (!d.ctrl.transmit_enable) begin
      d.st = UFT_ST_IDLE;
      d.tx_idle = 1'b1;
    end
    if (!PORT_ON_I) begin
      // Format, baud and the other control bits are left as they are
      d.ctrl.transmit_enable = 1'b0;
      d.ctrl.receive_enable = 1'b0;
      d.ctrl.break_send = 1'b0;
      d.hold_valid = 1'b0;
      d.armed = 1'b0;
      d.tx_idle = 1'b1;
      d.st = UFT_ST_IDLE;
    end
    case (d.st)
      UFT_ST_START: d.tx = 1'b0;
      UFT_ST_DATA:  d.tx = d.shift[0];
      default:      d.tx = 1'b1;
    endcase
  end

  // Control zero at reset gives 8 data bits, no parity; stop bits are always two
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      q.ctrl <= '0;
      q.div <= `UFT_DIV_RST;
      q.frac <= `UFT_FRAC_RST;
      q.hold <= 8'h00;
      q.hold_valid <= 1'b0;
      q.armed <= 1'b0;
      q.tx_idle <= 1'b1;
      q.st <= UFT_ST_IDLE;
      q.shift <= 9'h1FF;
      q.bit_cnt <= 4'h0;
      q.tx <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Receiver lives elsewhere; its flags sit at their disabled values
  always_comb begin
    STATUS_O = '0;
    STATUS_O.transmit_room_flag = !q.hold_valid;
    STATUS_O.transmit_idle_flag = q.tx_idle;
    STATUS_O.receive_idle_flag = 1'b1;
    STATUS_O.receive_fill_count = `UFT_FILL_EMPTY;
  end

  assign CTRL_O = q.ctrl;
  assign TX_O = q.tx;
  assign TX_OE_O = q.ctrl.transmit_enable;
  assign RX_SEL_O = q.ctrl.receive_enable;

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_idle_line_high: assert property (
    q.st == UFT_ST_IDLE |-> TX_O)
    else $error("line not high while idle");

  a_start_bit_low: assert property (
    q.st == UFT_ST_START |-> !TX_O ##0 TX_OE_O)
    else $error("start bit not low");

  a_disable_flags: assert property (
    !PORT_ON_I |=> !CTRL_O.transmit_enable && !CTRL_O.receive_enable
      && !CTRL_O.break_send && STATUS_O.transmit_room_flag
      && STATUS_O.transmit_idle_flag)
    else $error("disable left flags wrong");

  a_keep_format: assert property (
    !PORT_ON_I && !CTRL_WR_I && !BAUD_WR_I |=>
      $stable(CTRL_O.word_length_select) && $stable(q.div)
      && $stable(CTRL_O.parity_type_field))
    else $error("disable altered configuration");

  a_abort_now: assert property (
    !PORT_ON_I |=> q.st == UFT_ST_IDLE ##0 TX_O ##0 !TX_OE_O)
    else $error("port off did not abort");

  a_blocked_write: assert property (
    DATA_WR_I && q.hold_valid |=> $stable(q.hold))
    else $error("pending byte overwritten");

  a_room_sequence: assert property (
    $rose(q.hold_valid) |-> $past(q.armed) && $past(DATA_WR_I))
    else $error("room cleared without sequence");

  a_direct_start: assert property (
    write_ok && tx_go && q.st == UFT_ST_IDLE |=>
      q.st == UFT_ST_START ##0 !q.hold_valid)
    else $error("write to idle shifter did not start");

  a_two_rx_stop_count_select: assert property (
    q.st == UFT_ST_STOP && tick && q.bit_cnt == 4'h0 && tx_go |=>
      q.st == UFT_ST_STOP ##0 TX_O)
    else $error("transmitter sent one stop bit");

  a_no_enable: assert property (
    !CTRL_O.transmit_enable |-> q.st == UFT_ST_IDLE)
    else $error("shifting without enable");

  a_lsb_order: assert property (
    q.st == UFT_ST_DATA |-> TX_O == q.shift[0])
    else $error("data bit not taken from shifter bottom");

  a_stop_high: assert property (
    q.st == UFT_ST_STOP |-> TX_O)
    else $error("stop bit not high");

  a_rx_pin_free: assert property (
    !PORT_ON_I |=> !RX_SEL_O && STATUS_O.receive_idle_flag)
    else $error("receive pin kept while port off");

  a_stop_reload: assert property (
    q.st == UFT_ST_STOP && tick && q.bit_cnt == 4'h1 && q.hold_valid
      && tx_go && !CTRL_WR_I |=> q.st == UFT_ST_START && !q.hold_valid)
    else $error("waiting byte not loaded after rx_stop_count_select");

  a_no_early_load: assert property (
    q.st == UFT_ST_DATA |=> q.st != UFT_ST_START)
    else $error("shifter reloaded before stop bits");

  a_idle_clears: assert property (
    write_ok && tx_go && q.st == UFT_ST_IDLE && !CTRL_WR_I |=>
      !STATUS_O.transmit_idle_flag)
    else $error("idle flag not cleared by write");

  a_pin_release: assert property (
    !CTRL_O.transmit_enable |-> !TX_OE_O && TX_O)
    else $error("transmit pin held without enable");

  a_unarmed_write: assert property (
    DATA_WR_I && !q.armed |=> $stable(q.hold))
    else $error("unarmed write took a byte");

  a_read_arms: assert property (
    STATUS_RD_I && PORT_ON_I |=> q.armed)
    else $error("status access did not arm write");

  c_frame_sent: cover property ($rose(q.tx_idle));
  c_back_to_back: cover property (
    q.st == UFT_ST_STOP ##1 q.st == UFT_ST_START);
  c_abort_mid: cover property (q.st == UFT_ST_DATA ##1 !PORT_ON_I);
  c_nine_bit: cover property (
    q.st == UFT_ST_DATA && q.bit_cnt == 4'h8 && tick);
endmodule
